// [sccg_cfg.svh]
// offsets, field positions, reset values and cycle counts of the clock prescaler and sleep gate
`ifndef SCCG_CFG_SVH
`define SCCG_CFG_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define SCCG_ADR_DIVCTRL     8'h00
`define SCCG_ADR_SLEEPCTRL   8'h04
`define SCCG_ADR_STATUS      8'h08
`define SCCG_ADR_WAKECFG     8'h0c

// ************************************************************
// divider control fields
// ************************************************************
`define SCCG_UNLOCK_BIT      7
`define SCCG_UNLOCK_PATTERN  8'h80
`define SCCG_DIVSEL_FUSED    4'h3
`define SCCG_DIVSEL_PLAIN    4'h0
`define SCCG_DIVSEL_LAST     4'h8
`define SCCG_UNLOCK_CYCLES   3'h4

// ************************************************************
// sleep mode codes and wake timing
// ************************************************************
`define SCCG_MODE_IDLE       3'h0
`define SCCG_MODE_ADCQ       3'h1
`define SCCG_MODE_PDOWN      3'h2
`define SCCG_MODE_PSAVE      3'h3
`define SCCG_MODE_STBY       3'h6
`define SCCG_MODE_XSTBY      3'h7
`define SCCG_HOLD_CYCLES     4'h4
`define SCCG_STANDBY_WAKE    4'h6
`define SCCG_STARTUP_DEFAULT 6

`endif

// [sccg_pkg.sv]
// types shared by the clock prescaler and sleep gate
package sccg_pkg;

    typedef enum logic [1:0] {SCCG_RUN, SCCG_SLEEP, SCCG_WAKE, SCCG_HOLD} sccg_fsm_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic [3:0] shift;
        logic       tick;
    } sccg_div_state_t;

    typedef struct packed {
        sccg_fsm_t   fsm;
        logic [3:0]  divSel;
        logic        unlock;
        logic [2:0]  unlockCnt;
        logic        arm;
        logic [2:0]  mode;
        logic [2:0]  sleptMode;
        logic        timer2Async;
        logic [3:0]  upperLevel;
        logic [3:0]  waitCnt;
        logic        ack;
        logic [31:0] rdat;
        logic        cpuTick;
        logic        flashTick;
        logic        ioTick;
        logic        adcTick;
        logic        asyEn;
        logic        mainOscEn;
        logic        timerOscEn;
        logic        cpuHold;
    } sccg_state_t;

endpackage

// [sccg_divider.sv]
// glitch-free power-of-two divider producing one tick per divided period
`timescale 1ns/10ps
`default_nettype none
`include "sccg_cfg.svh"

module sccg_divider
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic [3:0] divSel,
    output logic            tick
);
    import sccg_pkg::*;

    sccg_div_state_t s;
    sccg_div_state_t n;

    function automatic logic [7:0] lastCount(input logic [3:0] sh);
        logic [8:0] full;
        full = (9'h001 << sh) - 9'h001;
        return full[7:0];
    endfunction

    // ************************************************************
    // counter; a new ratio is adopted only on a period boundary
    // ************************************************************
    always_comb
    begin
        n = s;
        n.tick = 1'b0;
        if (s.cnt == lastCount(s.shift))
        begin
            n.cnt = 8'h00;
            n.tick = 1'b1;
            // reserved codes leave the running ratio alone
            if (divSel <= `SCCG_DIVSEL_LAST)
            begin
                n.shift = divSel;
            end
        end
        else
        begin
            n.cnt = s.cnt + 8'h01;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign tick = s.tick;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    div_one_a: assert property (s.shift == 4'h0 |=> s.tick)
        else $error("division by one missed a tick");
    div_two_a: assert property (s.tick && s.shift == 4'h1 |=> !s.tick ##1 s.tick)
        else $error("division by two period wrong");
    reserved_keep_a: assert property (divSel > `SCCG_DIVSEL_LAST |=> $stable(s.shift))
        else $error("reserved divide code was adopted");

endmodule
`default_nettype wire

// [sccg_top.sv]
// system clock prescaler with unlock sequence and sleep-mode clock gating
`timescale 1ns/10ps
`default_nettype none
`include "sccg_cfg.svh"

// Overview of operation
// - unlock flag set only by exact pattern 0x80
// - divide select written only while unlocked
// - unlock clears after four cycles or on write
// - repeated unlock neither restarts nor clears window
// - codes 0..8 divide by 1..256, rest reserved
// - reset divide from fuse: 0011 or 0000
// - any divide value writable regardless of fuse
// - divided clock drives CPU and peripherals together
// - three-bit mode field picks the sleep mode
// - each mode keeps its own set of clocks
// - each mode wakes on its own source set
// - upper external interrupts wake only when level, except in idle
// - timer oscillator features need asynchronous timer clock
// - CPU held four cycles after start-up on wake
// - sleep leaves register file and SRAM untouched
// - reset during sleep restarts from reset vector
// - divide change is glitch-free, boundary aligned
// - mode codes 0,1,2,3,6,7; standby needs crystal
// - standby modes wake within six clock cycles
module sccg_top
#(
    parameter int STARTUP_CYCLES = `SCCG_STARTUP_DEFAULT
)
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        divEightFuse,
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [7:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatI,
    output logic      [31:0] wbDatO,
    output logic             wbAck,
    input  wire logic        sleepInstr,
    input  wire logic        crystalSelected,
    input  wire logic [7:0]  extIntReq,
    input  wire logic        pinChangeReq,
    input  wire logic        twiMatchReq,
    input  wire logic        timer2Req,
    input  wire logic        spmReadyReq,
    input  wire logic        adcDoneReq,
    input  wire logic        wdtReq,
    input  wire logic        otherIrqReq,
    output logic             cpuClkTick,
    output logic             flashClkTick,
    output logic             ioClkTick,
    output logic             adcClkTick,
    output logic             asyClkEn,
    output logic             mainOscEn,
    output logic             timerOscEn,
    output logic             cpuHold,
    output sccg_pkg::sccg_fsm_t powerState
);
    import sccg_pkg::*;

    sccg_state_t s;
    sccg_state_t n;
    logic        divTick;
    logic        busReq;
    logic        busWr;
    logic [6:0]  mask;
    logic        wakeNow;

    localparam logic [3:0] STARTUP_W = 4'(STARTUP_CYCLES);

    sccg_divider u_div
    (
        .clock  (clock),
        .nrst   (nrst),
        .divSel (s.divSel),
        .tick   (divTick)
    );

    // ************************************************************
    // mode helpers
    // ************************************************************
    function automatic logic modeValid(input logic [2:0] m, input logic xtal);
        if (m == `SCCG_MODE_STBY || m == `SCCG_MODE_XSTBY)
            return xtal;
        else if (m == `SCCG_MODE_IDLE || m == `SCCG_MODE_ADCQ)
            return 1'b1;
        else if (m == `SCCG_MODE_PDOWN || m == `SCCG_MODE_PSAVE)
            return 1'b1;
        else
            return 1'b0;
    endfunction

    // {cpu, flash, io, adc, asy, main, timer osc}
    function automatic logic [6:0] sleepMask(input logic [2:0] m, input logic t2a);
        logic [6:0] r;
        r = 7'h00;
        case (m)
            `SCCG_MODE_IDLE:  r = {4'b0011, 1'b1, 1'b1, t2a};
            `SCCG_MODE_ADCQ:  r = {4'b0001, 1'b1, 1'b1, t2a};
            `SCCG_MODE_PSAVE: r = {4'b0000, 1'b1, 1'b0, t2a};
            `SCCG_MODE_STBY:  r = {4'b0000, 1'b0, 1'b1, 1'b0};
            `SCCG_MODE_XSTBY: r = {4'b0000, t2a, 1'b1, t2a};
            default:          r = 7'h00;
        endcase
        return r;
    endfunction

    function automatic logic wakeAllowed(input logic [2:0] m, input logic t2a,
                                         input logic [3:0] lvl);
        logic extOk;
        logic base;
        extOk = (|extIntReq[3:0]) | (|(extIntReq[7:4] & lvl)) | pinChangeReq;
        base = extOk | twiMatchReq | wdtReq;
        case (m)
            `SCCG_MODE_IDLE:  return base | (|extIntReq[7:4]) | timer2Req | spmReadyReq
                                     | adcDoneReq | otherIrqReq;
            `SCCG_MODE_ADCQ:  return base | (timer2Req & t2a) | spmReadyReq | adcDoneReq;
            `SCCG_MODE_PSAVE: return base | timer2Req;
            `SCCG_MODE_XSTBY: return base | timer2Req;
            default:          return base;
        endcase
    endfunction

    function automatic logic [3:0] startupOf(input logic [2:0] m);
        if (m == `SCCG_MODE_STBY || m == `SCCG_MODE_XSTBY)
            return `SCCG_STANDBY_WAKE;
        else if (m == `SCCG_MODE_PDOWN || m == `SCCG_MODE_PSAVE)
            return STARTUP_W;
        else
            return 4'h0;
    endfunction

    assign busReq  = wbCyc & wbStb & ~s.ack;
    assign busWr   = busReq & wbWe & wbSel[0];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        n = s;
        n.ack = busReq;
        n.rdat = 32'h0000_0000;
        mask = 7'h00;
        // not in an assign: the function reads the request pins directly
        wakeNow = wakeAllowed(s.sleptMode, s.timer2Async, s.upperLevel);
        if (busReq && !wbWe)
        begin
            if (wbAdr == `SCCG_ADR_DIVCTRL)
                n.rdat = {24'h0, s.unlock, 3'b000, s.divSel};
            else if (wbAdr == `SCCG_ADR_SLEEPCTRL)
                n.rdat = {28'h0, s.mode, s.arm};
            else if (wbAdr == `SCCG_ADR_STATUS)
                n.rdat = {25'h0, s.sleptMode, s.cpuHold, 1'b0, s.fsm};
            else if (wbAdr == `SCCG_ADR_WAKECFG)
                n.rdat = {24'h0, s.upperLevel, 3'b000, s.timer2Async};
            else
                n.rdat = 32'h0000_0000;
        end

        // window runs out by itself; a repeat pattern does not touch it
        if (s.unlock)
        begin
            if (s.unlockCnt == `SCCG_UNLOCK_CYCLES)
                n.unlock = 1'b0;
            else
                n.unlockCnt = s.unlockCnt + 3'h1;
        end

        if (busWr && wbAdr == `SCCG_ADR_DIVCTRL)
        begin
            if (wbDatI[7:0] == `SCCG_UNLOCK_PATTERN)
            begin
                if (!s.unlock)
                begin
                    n.unlock = 1'b1;
                    n.unlockCnt = 3'h1;
                end
            end
            else if (!wbDatI[`SCCG_UNLOCK_BIT] && s.unlock)
            begin
                n.divSel = wbDatI[3:0];
                n.unlock = 1'b0;
            end
        end
        else if (busWr && wbAdr == `SCCG_ADR_SLEEPCTRL)
        begin
            n.arm = wbDatI[0];
            n.mode = wbDatI[3:1];
        end
        else if (busWr && wbAdr == `SCCG_ADR_WAKECFG)
        begin
            n.timer2Async = wbDatI[0];
            n.upperLevel = wbDatI[7:4];
        end

        // only clocks are stopped; no storage is cleared on the way in or out
        case (s.fsm)
            SCCG_RUN:
            begin
                if (sleepInstr && s.arm && modeValid(s.mode, crystalSelected))
                begin
                    n.fsm = SCCG_SLEEP;
                    n.sleptMode = s.mode;
                end
            end
            SCCG_SLEEP:
            begin
                if (wakeNow)
                begin
                    if (startupOf(s.sleptMode) == 4'h0)
                    begin
                        n.fsm = SCCG_HOLD;
                        n.waitCnt = `SCCG_HOLD_CYCLES - 4'h1;
                    end
                    else
                    begin
                        n.fsm = SCCG_WAKE;
                        n.waitCnt = startupOf(s.sleptMode) - 4'h1;
                    end
                end
            end
            SCCG_WAKE:
            begin
                if (s.waitCnt == 4'h0)
                begin
                    n.fsm = SCCG_HOLD;
                    n.waitCnt = `SCCG_HOLD_CYCLES - 4'h1;
                end
                else
                begin
                    n.waitCnt = s.waitCnt - 4'h1;
                end
            end
            SCCG_HOLD:
            begin
                if (s.waitCnt == 4'h0)
                    n.fsm = SCCG_RUN;
                else
                    n.waitCnt = s.waitCnt - 4'h1;
            end
            default:
            begin
                n.fsm = SCCG_RUN;
            end
        endcase

        // clock gates follow the state being entered, so they change with it
        case (n.fsm)
            SCCG_RUN:   mask = {6'h3f, n.timer2Async};
            SCCG_HOLD:  mask = {4'b0011, 2'b11, n.timer2Async};
            default:    mask = sleepMask(n.sleptMode, n.timer2Async);
        endcase
        n.cpuTick    = divTick & mask[6];
        n.flashTick  = divTick & mask[5];
        n.ioTick     = divTick & mask[4];
        n.adcTick    = divTick & mask[3];
        n.asyEn      = mask[2];
        n.mainOscEn  = mask[1];
        n.timerOscEn = mask[0];
        n.cpuHold    = (n.fsm != SCCG_RUN);
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            s <= '0;
            s.divSel <= divEightFuse ? `SCCG_DIVSEL_FUSED : `SCCG_DIVSEL_PLAIN;
        end
        else
        begin
            s <= n;
        end
    end

    assign wbDatO       = s.rdat;
    assign wbAck        = s.ack;
    assign cpuClkTick   = s.cpuTick;
    assign flashClkTick = s.flashTick;
    assign ioClkTick    = s.ioTick;
    assign adcClkTick   = s.adcTick;
    assign asyClkEn     = s.asyEn;
    assign mainOscEn    = s.mainOscEn;
    assign timerOscEn   = s.timerOscEn;
    assign cpuHold      = s.cpuHold;
    assign powerState   = s.fsm;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence holdThenRun;
        (s.fsm == SCCG_HOLD)[*4] ##1 (s.fsm == SCCG_RUN);
    endsequence
    sequence standbyWake;
        (s.fsm == SCCG_WAKE)[*6] ##1 holdThenRun;
    endsequence

    unlock_set_a: assert property (busWr && wbAdr == `SCCG_ADR_DIVCTRL && !s.unlock
        && wbDatI[7:0] == `SCCG_UNLOCK_PATTERN |=> s.unlock)
        else $error("unlock pattern did not set the flag");
    unlock_bad_a: assert property (busWr && wbAdr == `SCCG_ADR_DIVCTRL && !s.unlock
        && wbDatI[7] && wbDatI[6:0] != 7'h00 |=> !s.unlock)
        else $error("flag set by an impure pattern");
    field_lock_a: assert property (!s.unlock |=> $stable(s.divSel))
        else $error("divide select changed while locked");
    unlock_window_a: assert property ($rose(s.unlock) |-> ##4 !s.unlock)
        else $error("unlock window longer than four cycles");
    reset_fuse_a: assert property (@(posedge clock) disable iff (1'b0)
        !nrst |=> s.divSel == (($past(divEightFuse)) ? 4'h3 : 4'h0))
        else $error("divide select not loaded from fuse");
    no_arm_a: assert property (s.fsm == SCCG_RUN && !s.arm |=> s.fsm == SCCG_RUN)
        else $error("sleep entered without arm bit");
    pdown_clocks_a: assert property (s.fsm == SCCG_SLEEP
        && s.sleptMode == `SCCG_MODE_PDOWN |-> !(s.cpuTick || s.ioTick || s.adcTick
        || s.asyEn || s.mainOscEn || s.timerOscEn))
        else $error("clock running in power-down");
    hold_four_a: assert property ($rose(s.fsm == SCCG_HOLD) |-> holdThenRun)
        else $error("wake hold not four cycles");
    standby_wake_a: assert property (s.fsm == SCCG_SLEEP && wakeNow
        && s.sleptMode == `SCCG_MODE_STBY |=> standbyWake)
        else $error("standby wake not six cycles");

endmodule
`default_nettype wire

// [sccg_cpu_model.sv]
// cpu-side model: issues the sleep instruction and times the divided clock
`timescale 1ns/10ps
`default_nettype none
module sccg_cpu_model
(
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire logic                sleepGo,
    input  wire logic                cpuClkTick,
    input  wire logic                ioClkTick,
    input  wire sccg_pkg::sccg_fsm_t powerState,
    output logic                     sleepInstr,
    output logic [9:0]               period,
    output logic                     skew
);
    import sccg_pkg::*;
    logic [9:0] gapQ;
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            sleepInstr <= 1'b0;
            gapQ <= 10'h001;
            period <= 10'h000;
            skew <= 1'b0;
        end
        else
        begin
            // the bench writes the arm bit and mode before it asks for the instruction
            sleepInstr <= sleepGo;
            gapQ <= cpuClkTick ? 10'h001 : gapQ + 10'h001;
            if (cpuClkTick)
                period <= gapQ;
            // sticky: one lone tick while running is enough to show a split clock
            skew <= skew | ((powerState == SCCG_RUN) && (cpuClkTick != ioClkTick));
        end
    end
endmodule
`default_nettype wire

// [sysclk_prescaler_sleep_gating_test.sv]
// self-checking bench for the clock prescaler and sleep gate
`timescale 1ns/10ps
`default_nettype none
`include "sccg_cfg.svh"
module sysclk_prescaler_sleep_gating_test;
    import sccg_pkg::*;
    // ********
    // stimulus and observation
    // ********
    // short start-up keeps the power-down wake walk brief
    localparam int SU = 3;
    localparam logic [7:0] DIV = `SCCG_ADR_DIVCTRL;
    localparam logic [7:0] SLP = `SCCG_ADR_SLEEPCTRL;
    localparam logic [7:0] WCF = `SCCG_ADR_WAKECFG;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        fuse = 1'b1;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic        wbWe = 1'b0;
    logic [7:0]  wbAdr = 8'h00;
    logic [3:0]  wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0;
    logic [31:0] wbDatO;
    logic        wbAck, sleepGo = 1'b0, sleepInstr, crystal = 1'b1, skew;
    logic [14:0] irqs = 15'h0000;
    logic        cpuT, flT, ioT, adcT, asyEn, mainEn, toscEn, cpuHold;
    logic [9:0]  period;
    sccg_fsm_t   powerState;
    int          failCount = 0;
    int          testsRun = 0;

    always #12.5 clock = ~clock;

    sccg_top #(.STARTUP_CYCLES(SU)) DUT (.clock(clock), .nrst(nrst), .divEightFuse(fuse),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
        .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .sleepInstr(sleepInstr),
        .crystalSelected(crystal), .extIntReq(irqs[14:7]), .pinChangeReq(irqs[6]),
        .twiMatchReq(irqs[5]), .timer2Req(irqs[4]), .spmReadyReq(irqs[3]),
        .adcDoneReq(irqs[2]), .wdtReq(irqs[1]), .otherIrqReq(irqs[0]), .cpuClkTick(cpuT),
        .flashClkTick(flT), .ioClkTick(ioT), .adcClkTick(adcT), .asyClkEn(asyEn),
        .mainOscEn(mainEn), .timerOscEn(toscEn), .cpuHold(cpuHold), .powerState(powerState));

    sccg_cpu_model cpu (.clock(clock), .nrst(nrst), .sleepGo(sleepGo), .cpuClkTick(cpuT),
        .ioClkTick(ioT), .powerState(powerState), .sleepInstr(sleepInstr),
        .period(period), .skew(skew));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            failCount++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timeout(input string what);
        failCount++;
        $display("unexpected %s: expected an answer seen none", what);
        final_report();
    endtask

    task automatic do_reset(input logic f);
        fuse <= f;
        nrst <= 1'b0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
    endtask

    // values are taken at the edge before its own updates land
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                      output logic [7:0] rd);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'h1;
        wbDatI <= {24'h000000, dat};
        do
        begin
            @(posedge clock);
            n++;
            if (n > 50)
                timeout("bus ack");
        end
        while (wbAck !== 1'b1);
        rd = wbDatO[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [7:0] rd;
        wb(1'b1, adr, dat, rd);
    endtask

    task automatic rdc(input string what, input logic [7:0] adr, input logic [7:0] exp);
        logic [7:0] rd;
        wb(1'b0, adr, 8'h00, rd);
        check(what, {24'h0, rd}, {24'h0, exp});
    endtask

    // both writes fall three cycles apart, inside the four-cycle window
    task automatic setdiv(input logic [3:0] k);
        wr(DIV, `SCCG_UNLOCK_PATTERN);
        wr(DIV, {4'h0, k});
    endtask

    task automatic measure(input logic [9:0] exp);
        int n;
        int t;
        n = 0;
        t = 0;
        while (t < 5)
        begin
            @(posedge clock);
            n++;
            t += int'(cpuT);
            if (n > 2100)
                timeout("divided tick");
        end
        check("divided period", period, exp);
    endtask

    task automatic sleep_issue();
        sleepGo <= 1'b1;
        @(posedge clock);
        sleepGo <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic sleep_run(input logic [2:0] mode, input logic [7:0] cfg,
                             input logic [6:0] mask, input int wakeN,
                             input logic [14:0] blk, input logic [14:0] wake);
        int n;
        logic [6:0] seen;
        wr(WCF, cfg);
        wr(SLP, {4'h0, mode, 1'b1});
        sleep_issue();
        seen = 7'h00;
        repeat (8)
        begin
            @(posedge clock);
            seen |= {cpuT, flT, ioT, adcT, asyEn, mainEn, toscEn};
        end
        check("sleep state", powerState, SCCG_SLEEP);
        check("sleep hold", cpuHold, 1'b1);
        check("sleep clocks", seen, mask);
        irqs <= blk;
        repeat (4) @(posedge clock);
        check("blocked wake", powerState, SCCG_SLEEP);
        irqs <= blk | wake;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
            if (n > 40)
                timeout("wake");
        end
        while (powerState !== SCCG_RUN);
        irqs <= 15'h0000;
        check("wake cycles", n, 6 + wakeN);
        $display("test sleep mode %0d done", mode);
    endtask

    task automatic sleep_refused(input logic [7:0] ctrl, input logic xtal);
        crystal <= xtal;
        wr(SLP, ctrl);
        sleep_issue();
        check("refused sleep", powerState, SCCG_RUN);
        crystal <= 1'b1;
        $display("test refused sleep done");
    endtask

    initial
    begin
        do_reset(1'b1);
        rdc("divider control", DIV, 8'h03);
        measure(10'd8);
        rdc("unmapped", 8'h10, 8'h00);
        wr(DIV, 8'h81);
        wr(DIV, 8'h05);
        rdc("bad unlock", DIV, 8'h03);
        wr(DIV, 8'h80);
        rdc("unlock flag", DIV, 8'h83);
        wr(DIV, 8'h06);
        rdc("expired window", DIV, 8'h03);
        wr(DIV, 8'h80);
        wr(DIV, 8'h80);
        wr(DIV, 8'h06);
        rdc("no restart", DIV, 8'h03);
        setdiv(4'h5);
        rdc("new divide", DIV, 8'h05);
        setdiv(4'h9);
        rdc("reserved code", DIV, 8'h09);
        measure(10'd32);
        $display("test unlock done");
        for (int k = 8; k >= 0; k--)
        begin
            setdiv(k[3:0]);
            measure(10'(1 << k));
        end
        check("tick skew", skew, 1'b0);
        do_reset(1'b0);
        rdc("plain reset", DIV, 8'h00);
        $display("test divide codes done");
        sleep_run(`SCCG_MODE_IDLE, 8'h01, 7'h1f, 0, 15'h0000, 15'h0001);
        sleep_run(`SCCG_MODE_ADCQ, 8'h01, 7'h0f, 0, 15'h0001, 15'h0004);
        sleep_run(`SCCG_MODE_PDOWN, 8'h01, 7'h00, SU, 15'h1000, 15'h0100);
        sleep_run(`SCCG_MODE_PDOWN, 8'h21, 7'h00, SU, 15'h0001, 15'h1000);
        sleep_run(`SCCG_MODE_PSAVE, 8'h01, 7'h05, SU, 15'h0001, 15'h0010);
        sleep_run(`SCCG_MODE_STBY, 8'h01, 7'h02, 6, 15'h0010, 15'h0040);
        sleep_run(`SCCG_MODE_XSTBY, 8'h01, 7'h07, 6, 15'h0001, 15'h0020);
        sleep_run(`SCCG_MODE_ADCQ, 8'h00, 7'h0e, 0, 15'h0010, 15'h0002);
        sleep_run(`SCCG_MODE_XSTBY, 8'h00, 7'h02, 6, 15'h0001, 15'h0002);
        sleep_refused(8'h04, 1'b1);
        sleep_refused(8'h0d, 1'b0);
        sleep_refused(8'h09, 1'b1);
        wr(SLP, 8'h05);
        sleep_issue();
        check("asleep", powerState, SCCG_SLEEP);
        rdc("sleep control", SLP, 8'h05);
        rdc("sleep status", `SCCG_ADR_STATUS, 8'h29);
        do_reset(1'b1);
        check("reset wake", powerState, SCCG_RUN);
        check("reset hold", cpuHold, 1'b0);
        rdc("reset divide", DIV, 8'h03);
        $display("test reset in sleep done");
        final_report();
    end
endmodule
`default_nettype wire
